// ### tb/event_source_model.sv
/*
  Peripheral event source model: one-cycle event strobes and held buffer levels.
  Assumes the bench calls its tasks from one thread that is synced to clk.
*/
`timescale 1ns/1ps
`default_nettype none

module event_source_model
  import irq_flags_pkg::*;
(
  input wire logic clk,
  output var logic slave_port_access,
  output var logic converter_done,
  output var logic serial_rx_full,
  output var logic serial_tx_empty,
  output var logic usb_irq_event,
  output var logic capcomp_one_capture,
  output var logic capcomp_one_match,
  output var capcomp_mode_e capcomp_one_mode,
  output var logic timer_two_match,
  output var logic timer_one_overflow,
  output var logic capcomp_two_event
);
  // ----------------------------------------------------------------
  // idle state from time zero
  // ----------------------------------------------------------------
  initial begin
    {slave_port_access, converter_done, usb_irq_event, capcomp_one_capture} = 4'h0;
    {capcomp_one_match, timer_two_match, timer_one_overflow, capcomp_two_event} = 4'h0;
    {serial_rx_full, serial_tx_empty} = 2'b00;
    capcomp_one_mode = CAPCOMP_CAPTURE;
  end

  // strobe map: 0 t1, 1 t2, 2 capture, 3 usb, 4 match, 6 adc, 7 port, 8 cc2
  task automatic drive(input logic [9:0] m);
    timer_one_overflow <= m[0];
    timer_two_match <= m[1];
    capcomp_one_capture <= m[2];
    usb_irq_event <= m[3];
    capcomp_one_match <= m[4];
    converter_done <= m[6];
    slave_port_access <= m[7];
    capcomp_two_event <= m[8];
  endtask

  // strobes last exactly one clock, so a stuck strobe cannot mask a lost set
  task automatic fire(input logic [9:0] m);
    @(posedge clk);
    drive(m);
    @(posedge clk);
    drive(10'h000);
  endtask

  // buffer levels stay until changed, like a peripheral not yet served
  task automatic levels(input logic rx, input logic tx, input capcomp_mode_e md);
    @(posedge clk);
    serial_rx_full <= rx;
    serial_tx_empty <= tx;
    capcomp_one_mode <= md;
  endtask
endmodule // event_source_model

`default_nettype wire

// ### tb/peripheral_interrupt_flags_tb.sv
/*
  Self-checking bench of the peripheral interrupt flag block: APB master,
  random and corner event traffic. Assumes a 125 MHz clk and the source model.
*/
`timescale 1ns/1ps
`default_nettype none
`include "irq_flags_map.svh"

module peripheral_interrupt_flags_tb;
  import irq_flags_pkg::*;
  localparam logic [11:0] A_CC = {`IDX_CORE_CTRL, 2'b00};
  localparam logic [11:0] A_F1 = {`IDX_FLAGS_ONE, 2'b00};
  localparam logic [11:0] A_F2 = {`IDX_FLAGS_TWO, 2'b00};
  localparam logic [11:0] A_ST = {`IDX_EVT_STATUS, 2'b00};
  localparam logic [11:0] A_CL = {`IDX_EVT_CLEAR, 2'b00};
  localparam logic [11:0] A_EN = {`IDX_EVT_ENABLE, 2'b00};
  localparam logic [11:0] A_E1 = {`IDX_ENABLES_ONE, 2'b00};
  localparam logic [11:0] A_E2 = {`IDX_ENABLES_TWO, 2'b00};
  localparam logic [11:0] REGS [8] = '{A_CC, A_F1, A_F2, A_ST, A_CL, A_EN, A_E1, A_E2};
  localparam int SW_BITS [6] = '{0, 1, 2, 3, 6, 7};
  // variant under test; 0 makes bit 7 reserved in flags and enables
  localparam int unsigned HAS_SP = 1;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, peripheral_request, event_irq;
  logic slave_port_access, converter_done, serial_rx_full, serial_tx_empty, usb_irq_event;
  logic capcomp_one_capture, capcomp_one_match, timer_two_match, timer_one_overflow, capcomp_two_event;
  capcomp_mode_e capcomp_one_mode;
  int miscompares = 0;
  int samples_checked = 0;
  logic [31:0] rd;
  logic err;

  always #4 clk = ~clk;

  peripheral_interrupt_flags #(.HAS_SLAVE_PORT(HAS_SP)) i_peripheral_interrupt_flags (.clk, .rst_b, .ce,
    .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .slave_port_access, .converter_done,
    .serial_rx_full, .serial_tx_empty, .usb_irq_event, .capcomp_one_capture, .capcomp_one_match,
    .capcomp_one_mode, .timer_two_match, .timer_one_overflow, .capcomp_two_event,
    .peripheral_request, .event_irq);

  event_source_model i_event_source_model (.clk, .slave_port_access, .converter_done,
    .serial_rx_full, .serial_tx_empty, .usb_irq_event, .capcomp_one_capture, .capcomp_one_match,
    .capcomp_one_mode, .timer_two_match, .timer_one_overflow, .capcomp_two_event);

  // ----------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // ----------------------------------------------------------------
  // apb master: request held until pready is sampled high
  // ----------------------------------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (pready !== 1'b1) begin
      miscompares++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, rd, exp);
  endtask

  // ----------------------------------------------------------------
  // expectations
  // ----------------------------------------------------------------
  // flags one in capture mode, from a strobe mask and the buffer levels
  function automatic logic [7:0] f1_exp(input logic [9:0] m, input logic rx, input logic tx);
    return {m[7] & (HAS_SP != 0), m[6], rx, tx, m[3], m[2], m[1], m[0]};
  endfunction

  function automatic logic req_exp(input logic [1:0] gp, input logic [7:0] f1, input logic [7:0] e1,
                                   input logic f2, input logic e2);
    return gp[1] & gp[0] & ((|(f1 & e1)) | (f2 & e2));
  endfunction

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [9:0] m;
    logic [7:0] e1;
    logic [1:0] gp;
    logic e2, rx, tx;
    void'($urandom(11));
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    foreach (REGS[i]) rdchk("reset value", REGS[i], 32'h0000_0000);
    chk("idle request", {31'h0, peripheral_request}, 32'h0000_0000);
    apb(1'b0, 12'hFFC, 32'h0000_0000);
    chk("unmapped error", {31'h0, err}, 32'h0000_0001);
    chk("unmapped data", rd, 32'h0000_0000);
    $display("test reset done");
    // random enables, gating and events; flags cleared before enabling
    for (int k = 0; k < 24; k++) begin
      e1 = 8'($urandom) & ((HAS_SP != 0) ? 8'hFF : 8'h7F);
      e2 = 1'($urandom);
      gp = 2'($urandom);
      m = 10'($urandom) & 10'h1CF;
      rx = 1'($urandom);
      tx = 1'($urandom);
      i_event_source_model.levels(rx, tx, CAPCOMP_CAPTURE);
      wr(A_F1, 32'h0000_0000);
      wr(A_F2, 32'h0000_0000);
      wr(A_E1, {24'h0, e1});
      wr(A_E2, {31'h0, e2});
      wr(A_CC, {24'h0, gp, 6'h0});
      i_event_source_model.fire(m);
      rdchk("flags one", A_F1, {24'h0, f1_exp(m, rx, tx)});
      rdchk("flags two", A_F2, {31'h0, m[8]});
      rdchk("enables one", A_E1, {24'h0, e1});
      rdchk("enables two", A_E2, {31'h0, e2});
      chk("request", {31'h0, peripheral_request}, {31'h0, req_exp(gp, f1_exp(m, rx, tx), e1, m[8], e2)});
    end
    $display("test random done");
    // every gate combination with an enabled pending flag
    i_event_source_model.levels(1'b0, 1'b0, CAPCOMP_CAPTURE);
    wr(A_F1, 32'h0000_0000);
    // a leftover capcomp two flag would otherwise hold the request up
    wr(A_F2, 32'h0000_0000);
    wr(A_E1, 32'h0000_00FF);
    i_event_source_model.fire(10'h001);
    for (int g = 0; g < 4; g++) begin
      wr(A_CC, 32'(g) << 6);
      // the write lands at the access edge, so look one edge later
      @(posedge clk);
      chk("gated request", {31'h0, peripheral_request}, {31'h0, g == 3});
    end
    wr(A_E1, 32'h0000_0000);
    @(posedge clk);
    chk("masked request", {31'h0, peripheral_request}, 32'h0000_0000);
    // software flags stay set until a write of zero
    foreach (SW_BITS[i]) begin
      wr(A_F1, 32'h0000_0000);
      i_event_source_model.fire(10'(1) << SW_BITS[i]);
      repeat (5) @(posedge clk);
      rdchk("sticky flag", A_F1, 32'(1) << SW_BITS[i]);
      wr(A_F1, 32'h0000_0000);
      rdchk("cleared flag", A_F1, 32'h0000_0000);
    end
    // capture and match strobes under every mode code
    for (int md = 0; md < 4; md++) begin
      i_event_source_model.levels(1'b0, 1'b0, capcomp_mode_e'(md));
      wr(A_F1, 32'h0000_0000);
      i_event_source_model.fire(10'h004);
      rdchk("capture by mode", A_F1, {29'h0, md == 0, 2'b00});
      wr(A_F1, 32'h0000_0000);
      i_event_source_model.fire(10'h010);
      rdchk("match by mode", A_F1, {29'h0, md == 1, 2'b00});
    end
    $display("test flags done");
    // buffer levels are read-only mirrors
    i_event_source_model.levels(1'b1, 1'b1, CAPCOMP_CAPTURE);
    rdchk("levels shown", A_F1, 32'h0000_0030);
    wr(A_F1, 32'h0000_0000);
    rdchk("levels kept", A_F1, 32'h0000_0030);
    i_event_source_model.levels(1'b0, 1'b0, CAPCOMP_CAPTURE);
    wr(A_F1, 32'h0000_0030);
    rdchk("levels not writable", A_F1, 32'h0000_0000);
    // strobe lands on the access edge of a clearing write
    wr(A_F1, 32'h0000_0001);
    fork
      wr(A_F1, 32'h0000_0000);
      begin
        @(posedge clk);
        i_event_source_model.fire(10'h001);
      end
    join
    rdchk("set beats clear", A_F1, 32'h0000_0001);
    $display("test levels done");
    // sticky event bank: raise, mask, clear
    wr(A_CL, 32'h0000_01FF);
    wr(A_EN, 32'h0000_0000);
    i_event_source_model.fire(10'h100);
    rdchk("event status", A_ST, 32'h0000_0100);
    chk("masked event irq", {31'h0, event_irq}, 32'h0000_0000);
    wr(A_EN, 32'h0000_0100);
    @(posedge clk);
    chk("event irq", {31'h0, event_irq}, 32'h0000_0001);
    wr(A_ST, 32'h0000_0000);
    rdchk("status read-only", A_ST, 32'h0000_0100);
    rdchk("clear reads zero", A_CL, 32'h0000_0000);
    wr(A_CL, 32'h0000_0100);
    rdchk("status cleared", A_ST, 32'h0000_0000);
    chk("irq released", {31'h0, event_irq}, 32'h0000_0000);
    // clock enable low across the setup edge stretches the access
    fork
      rdchk("ce stall read", A_F1, 32'h0000_0001);
      begin
        @(posedge clk);
        ce <= 1'b0;
        repeat (3) @(posedge clk);
        ce <= 1'b1;
      end
    join
    $display("test events done");
    final_report();
  end
endmodule // peripheral_interrupt_flags_tb

`default_nettype wire

// ### verilog/irq_flags_map.svh
/*
  Register indices, field positions and reset values of the peripheral
  interrupt flag block. Assumes byte address = index * 4 on the APB.
*/
`ifndef IRQ_FLAGS_MAP_SVH
`define IRQ_FLAGS_MAP_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_CORE_CTRL 10'h00B
`define IDX_FLAGS_ONE 10'h00C
`define IDX_FLAGS_TWO 10'h00D
`define IDX_EVT_STATUS 10'h010
`define IDX_EVT_CLEAR 10'h011
`define IDX_EVT_ENABLE 10'h012
`define IDX_ENABLES_ONE 10'h08C
`define IDX_ENABLES_TWO 10'h08D

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BIT_SLAVE_PORT 7
`define BIT_CONVERTER 6
`define BIT_SERIAL_RX 5
`define BIT_SERIAL_TX 4
`define BIT_USB 3
`define BIT_CAPCOMP_ONE 2
`define BIT_TIMER_TWO 1
`define BIT_TIMER_ONE 0
`define BIT_CAPCOMP_TWO 0
`define BIT_GLOBAL_EN 7
`define BIT_GROUP_EN 6
`define EVT_CAPCOMP_TWO 8
`define EVT_WIDTH 9

// ----------------------------------------------------------------
// masks and reset values
// ----------------------------------------------------------------
`define FLAGS_ONE_SW_MASK 8'hCF
`define FULL_MASK 8'hFF
`define RESERVED_MASK 8'h7F
`define BYTE_RESET 8'h00
`define RDATA_ZERO 32'h0000_0000

`endif

// ### verilog/irq_flags_pkg.sv
/*
  Types shared by the peripheral interrupt flag block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package irq_flags_pkg;

  // capture/compare unit operating mode
  typedef enum logic [1:0] {
    CAPCOMP_CAPTURE = 2'b00,
    CAPCOMP_COMPARE = 2'b01,
    CAPCOMP_PWM = 2'b10
  } capcomp_mode_e;

  // state of the flag block apart from the sticky event bank
  typedef struct packed {
    logic [7:0] flags_one;
    logic [7:0] enables_one;
    logic flags_two;
    logic enables_two;
    logic global_en;
    logic group_en;
    logic rx_prev;
    logic tx_prev;
    logic loaded;
    logic [31:0] rdata;
  } periph_state_s;

endpackage

// ### verilog/peripheral_interrupt_flags.sv
/*
  Peripheral interrupt enable and flag registers behind an APB slave,
  with gated request to the core and a sticky event interrupt.
  Assumes event strobes, levels and APB come from logic on clk.
*/
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "irq_flags_map.svh"

module peripheral_interrupt_flags
  import irq_flags_pkg::*;
#(
  parameter int unsigned HAS_SLAVE_PORT = 1,
  parameter int unsigned ADDR_W = 12
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic slave_port_access,
  input wire logic converter_done,
  input wire logic serial_rx_full,
  input wire logic serial_tx_empty,
  input wire logic usb_irq_event,
  input wire logic capcomp_one_capture,
  input wire logic capcomp_one_match,
  input wire capcomp_mode_e capcomp_one_mode,
  input wire logic timer_two_match,
  input wire logic timer_one_overflow,
  input wire logic capcomp_two_event,
  output logic peripheral_request,
  output logic event_irq
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (HAS_SLAVE_PORT > 1) begin : g_bad_variant
    $error("HAS_SLAVE_PORT must be 0 or 1");
  end
  if (ADDR_W < 12 || ADDR_W > 32) begin : g_bad_addr
    $error("ADDR_W must be 12..32");
  end

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  periph_state_s q;
  periph_state_s d;
  logic [7:0] sp_mask;
  logic [7:0] ev_one;
  logic [7:0] flags_view;
  logic [`EVT_WIDTH-1:0] evt_set;
  logic [`EVT_WIDTH-1:0] evt_status;
  logic [`EVT_WIDTH-1:0] evt_enable;
  logic [31:0] rd_val;
  logic wr_en;
  logic hit_ctrl;
  logic hit_flags_one;
  logic hit_flags_two;
  logic hit_en_one;
  logic hit_en_two;
  logic hit_evt_status;
  logic hit_evt_clear;
  logic hit_evt_enable;
  logic mapped;
  logic any_pending;

  // word-aligned address match against a register index
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                   input logic [9:0] idx);
    return a == ADDR_W'({idx, 2'b00});
  endfunction

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  assign hit_ctrl = reg_hit(paddr, `IDX_CORE_CTRL);
  assign hit_flags_one = reg_hit(paddr, `IDX_FLAGS_ONE);
  assign hit_flags_two = reg_hit(paddr, `IDX_FLAGS_TWO);
  assign hit_en_one = reg_hit(paddr, `IDX_ENABLES_ONE);
  assign hit_en_two = reg_hit(paddr, `IDX_ENABLES_TWO);
  assign hit_evt_status = reg_hit(paddr, `IDX_EVT_STATUS);
  assign hit_evt_clear = reg_hit(paddr, `IDX_EVT_CLEAR);
  assign hit_evt_enable = reg_hit(paddr, `IDX_EVT_ENABLE);
  assign mapped = hit_ctrl | hit_flags_one | hit_flags_two | hit_en_one |
                  hit_en_two | hit_evt_status | hit_evt_clear | hit_evt_enable;

  // ----------------------------------------------------------------
  // apb handshake
  // ----------------------------------------------------------------
  // read data is captured before pready so prdata comes from a flop
  assign pready = psel & penable & ce & q.loaded;
  assign pslverr = pready & ~mapped;
  assign wr_en = pready & pwrite & mapped;
  assign prdata = q.rdata;

  // bit 7 reserved on the variant without a slave port
  assign sp_mask = (HAS_SLAVE_PORT != 0) ? `FULL_MASK : `RESERVED_MASK;

  // ----------------------------------------------------------------
  // event collection
  // ----------------------------------------------------------------
  // pwm mode and illegal mode codes drop capcomp one events
  always_comb begin
    ev_one = `BYTE_RESET;
    ev_one[`BIT_SLAVE_PORT] = slave_port_access;
    ev_one[`BIT_CONVERTER] = converter_done;
    ev_one[`BIT_USB] = usb_irq_event;
    ev_one[`BIT_TIMER_TWO] = timer_two_match;
    ev_one[`BIT_TIMER_ONE] = timer_one_overflow;
    unique case (capcomp_one_mode)
      CAPCOMP_CAPTURE: ev_one[`BIT_CAPCOMP_ONE] = capcomp_one_capture;
      CAPCOMP_COMPARE: ev_one[`BIT_CAPCOMP_ONE] = capcomp_one_match;
      CAPCOMP_PWM: ev_one[`BIT_CAPCOMP_ONE] = 1'b0;
      default: ev_one[`BIT_CAPCOMP_ONE] = 1'b0;
    endcase
    ev_one = ev_one & sp_mask;
  end

  // serial flags are live levels, not stored state
  always_comb begin
    flags_view = q.flags_one & `FLAGS_ONE_SW_MASK;
    flags_view[`BIT_SERIAL_RX] = serial_rx_full;
    flags_view[`BIT_SERIAL_TX] = serial_tx_empty;
  end

  // sticky events: flag sets plus rising edges of serial levels
  always_comb begin
    evt_set = {1'b0, ev_one};
    evt_set[`BIT_SERIAL_RX] = serial_rx_full & ~q.rx_prev;
    evt_set[`BIT_SERIAL_TX] = serial_tx_empty & ~q.tx_prev;
    evt_set[`EVT_CAPCOMP_TWO] = capcomp_two_event;
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_val = `RDATA_ZERO;
    if (hit_flags_one) begin
      rd_val = 32'(flags_view);
    end else if (hit_flags_two) begin
      rd_val[`BIT_CAPCOMP_TWO] = q.flags_two;
    end else if (hit_en_one) begin
      rd_val = 32'(q.enables_one);
    end else if (hit_en_two) begin
      rd_val[`BIT_CAPCOMP_TWO] = q.enables_two;
    end else if (hit_ctrl) begin
      rd_val[`BIT_GLOBAL_EN] = q.global_en;
      rd_val[`BIT_GROUP_EN] = q.group_en;
    end else if (hit_evt_status) begin
      rd_val = 32'(evt_status);
    end else if (hit_evt_enable) begin
      rd_val = 32'(evt_enable);
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    // flags: software value first, events ORed after so they win
    if (wr_en && hit_flags_one) begin
      d.flags_one = ((pwdata[7:0] & `FLAGS_ONE_SW_MASK) | ev_one) & sp_mask;
    end else begin
      d.flags_one = (q.flags_one | ev_one) & sp_mask;
    end
    if (wr_en && hit_flags_two) begin
      d.flags_two = pwdata[`BIT_CAPCOMP_TWO] | capcomp_two_event;
    end else begin
      d.flags_two = q.flags_two | capcomp_two_event;
    end
    // enables: plain read/write
    if (wr_en && hit_en_one) begin
      d.enables_one = pwdata[7:0] & sp_mask;
    end
    if (wr_en && hit_en_two) begin
      d.enables_two = pwdata[`BIT_CAPCOMP_TWO];
    end
    if (wr_en && hit_ctrl) begin
      d.global_en = pwdata[`BIT_GLOBAL_EN];
      d.group_en = pwdata[`BIT_GROUP_EN];
    end
    d.rx_prev = serial_rx_full;
    d.tx_prev = serial_tx_empty;
    // capture read data in setup, or late if ce was low then
    d.loaded = psel & ~(penable & q.loaded);
    if (psel && !(penable && q.loaded)) begin
      d.rdata = rd_val;
    end
  end

  // all state held while ce is low
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // core request and event interrupt
  // ----------------------------------------------------------------
  // flag AND enable per source, then both group gates
  assign any_pending = |(flags_view & q.enables_one) | (q.flags_two & q.enables_two);
  assign peripheral_request = q.global_en & q.group_en & any_pending;

  sticky_irq_bank #(
    .WIDTH(`EVT_WIDTH)
  ) u_events (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .set_pulse(evt_set),
    .clear_wr(wr_en & hit_evt_clear),
    .clear_bits(pwdata[`EVT_WIDTH-1:0]),
    .enable_wr(wr_en & hit_evt_enable),
    .enable_bits(pwdata[`EVT_WIDTH-1:0]),
    .status(evt_status),
    .enable(evt_enable),
    .irq(event_irq)
  );

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  enable_write_lands_a: assert property (
    wr_en && hit_en_one |=> q.enables_one == ($past(pwdata[7:0]) & sp_mask))
    else $error("enable register did not take the written value");

  converter_sets_a: assert property (
    ce && converter_done && !q.enables_one[`BIT_CONVERTER] |=> q.flags_one[`BIT_CONVERTER])
    else $error("converter flag not set while its enable was low");

  set_beats_clear_a: assert property (
    ce && timer_one_overflow && wr_en && hit_flags_one && !pwdata[`BIT_TIMER_ONE]
    |=> q.flags_one[`BIT_TIMER_ONE])
    else $error("software clear lost a timer one overflow");

  timer_two_holds_a: assert property (
    q.flags_one[`BIT_TIMER_TWO] && !(wr_en && hit_flags_one)
    |=> q.flags_one[`BIT_TIMER_TWO] [*2] or (wr_en && hit_flags_one))
    else $error("timer two flag dropped without a write");

  rx_read_live_a: assert property (
    ce && psel && !penable && hit_flags_one |=> prdata[`BIT_SERIAL_RX] == $past(serial_rx_full))
    else $error("receive flag read does not follow buffer level");

  tx_read_live_a: assert property (
    ce && psel && !penable && hit_flags_one |=> prdata[`BIT_SERIAL_TX] == $past(serial_tx_empty))
    else $error("transmit flag read does not follow buffer level");

  pwm_ignores_a: assert property (
    ce && capcomp_one_mode == CAPCOMP_PWM && !q.flags_one[`BIT_CAPCOMP_ONE]
    && !(wr_en && hit_flags_one) |=> !q.flags_one[`BIT_CAPCOMP_ONE])
    else $error("capcomp one flag set in pwm mode");

  capture_sets_a: assert property (
    ce && capcomp_one_mode == CAPCOMP_CAPTURE && capcomp_one_capture
    |=> q.flags_one[`BIT_CAPCOMP_ONE])
    else $error("capture event did not set capcomp one flag");

  usb_sets_a: assert property (
    ce && usb_irq_event |=> q.flags_one[`BIT_USB])
    else $error("usb flag not set");

  slave_port_sets_a: assert property (
    ce && slave_port_access |=> q.flags_one[`BIT_SLAVE_PORT] == (HAS_SLAVE_PORT != 0))
    else $error("slave port flag wrong after port access");

  reserved_zero_a: assert property (
    HAS_SLAVE_PORT == 0 |-> !q.enables_one[`BIT_SLAVE_PORT] && !q.flags_one[`BIT_SLAVE_PORT])
    else $error("reserved bit 7 became set");

  capcomp_two_sets_a: assert property (
    ce && capcomp_two_event |=> q.flags_two ##1 q.flags_two || $past(wr_en))
    else $error("capcomp two flag not set or lost");

  request_gated_a: assert property (
    peripheral_request |-> q.global_en && q.group_en)
    else $error("request without global and group enable");

  request_cause_a: assert property (
    q.global_en && q.group_en && q.flags_one[`BIT_TIMER_ONE] && q.enables_one[`BIT_TIMER_ONE]
    |-> peripheral_request)
    else $error("enabled pending flag gave no request");

  ctrl_write_gates_a: assert property (
    wr_en && hit_ctrl && !pwdata[`BIT_GLOBAL_EN] |=> !peripheral_request)
    else $error("request survives clearing the global enable");

  apb_zero_wait_a: assert property (
    ce && psel && !penable ##1 ce && psel && penable |-> pready)
    else $error("apb access not answered in first access cycle");

  // ----------------------------------------------------------------
  // covers
  // ----------------------------------------------------------------
  request_seen_c: cover property (peripheral_request);
  set_clear_clash_c: cover property (ce && timer_one_overflow && wr_en && hit_flags_one);
  unmapped_access_c: cover property (pslverr);
  event_irq_rise_c: cover property (!event_irq ##1 event_irq);

endmodule // peripheral_interrupt_flags

`default_nettype wire

// ### verilog/sticky_irq_bank.sv
/*
  Sticky event status bank with write-one-to-clear and enable mask,
  driving one level interrupt. Assumes strobes from the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module sticky_irq_bank #(
  parameter int unsigned WIDTH = 9
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [WIDTH-1:0] set_pulse,
  input wire logic clear_wr,
  input wire logic [WIDTH-1:0] clear_bits,
  input wire logic enable_wr,
  input wire logic [WIDTH-1:0] enable_bits,
  output logic [WIDTH-1:0] status,
  output logic [WIDTH-1:0] enable,
  output logic irq
);

  typedef struct packed {
    logic [WIDTH-1:0] status;
    logic [WIDTH-1:0] enable;
  } bank_state_s;

  bank_state_s q;
  bank_state_s d;

  if (WIDTH < 1 || WIDTH > 32) begin : g_bad_width
    $error("sticky_irq_bank: WIDTH must be 1..32");
  end

  // set applied after clear so a same-cycle event survives
  always_comb begin
    d = q;
    if (clear_wr) begin
      d.status = q.status & ~clear_bits;
    end
    d.status = d.status | set_pulse;
    if (enable_wr) begin
      d.enable = enable_bits;
    end
  end

  // state frozen while ce is low
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign status = q.status;
  assign enable = q.enable;
  assign irq = |(q.status & q.enable);

endmodule // sticky_irq_bank

`default_nettype wire
